// File: logic/tct_timer.sv
/*
 The timer itself: prescaler, 16-bit modulo counter, two channels.
 Assumes the register link is driven on sys_clk and that break and
 clear-enable come from the system integration unit on the same clock.
*/
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module tct_timer (
    input wire logic sys_clk,
    input wire logic rst,
    tct_reg_if.dev bus,
    input wire logic debugBreak,
    input wire logic breakClearEnable,
    input wire logic [1:0][15:0] chValue,
    input wire logic [1:0] chPinIn,
    output logic [1:0] chPinOut,
    output logic [1:0] chPinOe_n,
    output logic ovfIrq,
    output logic [1:0] chIrq
);
    import tct_pkg::*;

    logic overflow_flag;
    logic overflow_irq_enable;
    logic halt;
    logic [2:0] ps;
    logic tofArmed;
    logic [15:0] cnt;
    logic [15:0] modulo;
    logic [5:0] pre;
    logic modInhibit;
    logic [7:0] latchLow;
    logic latched;
    logic [7:0] rdata;
    logic ready;
    logic [1:0][7:0] chReg;

    // ------------------------------------------------------------
    // Link decode.
    // ------------------------------------------------------------
    // A request is taken once; ready masks the held select.
    wire take = bus.sel && !ready;
    wire wr = take && bus.write;
    wire rd = take && !bus.write;
    wire wrSc = wr && bus.addr == IDX_SC;
    wire rdSc = rd && bus.addr == IDX_SC;
    wire rdCntHi = rd && bus.addr == IDX_CNT_HI;
    wire rdCntLo = rd && bus.addr == IDX_CNT_LO;
    wire wrModHi = wr && bus.addr == IDX_MOD_HI;
    wire wrModLo = wr && bus.addr == IDX_MOD_LO;

    // ------------------------------------------------------------
    // Counting.
    // ------------------------------------------------------------
    // Break with clear-enable low freezes every flag side effect.
    wire flagsLocked = debugBreak && !breakClearEnable;
    wire running = !halt && !debugBreak;
    wire counterReset = wrSc && bus.wdata[SC_RST_BIT];
    // Only the bus clock feeds the divider; there is no pin source.
    wire [5:0] tickMask = 6'((7'h1 << ps) - 7'h1);
    wire tick = running && !counterReset && ps != PS_UNUSED
        && ((pre & tickMask) == tickMask);
    wire [15:0] nextCnt = (cnt == modulo) ? CNT_RESET
        : cnt + 16'h0001;
    wire ovfEvent = tick && nextCnt == modulo && !modInhibit;

    // Prescaler and counter; a counter reset wins over any tick.
    always_ff @(posedge sys_clk) begin
        if (rst || counterReset) begin
            pre <= 6'h00;
            cnt <= CNT_RESET;
        end else if (running) begin
            pre <= pre + 6'h01;
            if (tick) begin
                cnt <= nextCnt;
            end
        end
    end

    // ------------------------------------------------------------
    // Status and control register.
    // ------------------------------------------------------------
    // An overflow in the clearing cycle wins, so no request is lost.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            overflow_flag <= 1'b0;
            overflow_irq_enable <= 1'b0;
            halt <= 1'b1;
            ps <= 3'h0;
            tofArmed <= 1'b0;
        end else begin
            if (wrSc) begin
                overflow_irq_enable <= bus.wdata[SC_IE_BIT];
                halt <= bus.wdata[SC_HALT_BIT];
                ps <= bus.wdata[SC_PS_LSB +: 3];
            end
            if (ovfEvent) begin
                overflow_flag <= 1'b1;
            end else if (wrSc && !bus.wdata[SC_FLAG_BIT] && tofArmed
                && !flagsLocked) begin
                overflow_flag <= 1'b0;
            end
            if (ovfEvent) begin
                tofArmed <= 1'b0;
            end else if (rdSc && overflow_flag && !flagsLocked) begin
                tofArmed <= 1'b1;
            end else if (wrSc && !flagsLocked) begin
                tofArmed <= 1'b0;
            end
        end
    end

    assign ovfIrq = overflow_flag && overflow_irq_enable;

    // ------------------------------------------------------------
    // Counter read latch and modulo.
    // ------------------------------------------------------------
    // The latch is not a status bit, so a break does not stop it; it
    // simply waits for the low-byte read, even after the break ends.
    always_ff @(posedge sys_clk) begin
        if (rst || counterReset) begin
            latched <= 1'b0;
            latchLow <= 8'h00;
        end else if (rdCntHi && !latched) begin
            latched <= 1'b1;
            latchLow <= cnt[7:0];
        end else if (rdCntLo) begin
            latched <= 1'b0;
        end
    end

    // Writes go straight in; compare against a half-written value is
    // blocked only for the overflow flag, so reset the counter first.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            modulo <= MOD_RESET;
            modInhibit <= 1'b0;
        end else if (wrModHi) begin
            modulo[15:8] <= bus.wdata;
            modInhibit <= 1'b1;
        end else if (wrModLo) begin
            modulo[7:0] <= bus.wdata;
            modInhibit <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Channels.
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : gCh
        logic [2:0] pinSync;
        logic flag;
        logic ie;
        logic cmpMode;
        logic [1:0] edgeSel;
        logic armed;
        logic pinLevel;
        wire rdCh = rd && bus.addr == 3'(IDX_CH0 + 3'(i));
        wire wrCh = wr && bus.addr == 3'(IDX_CH0 + 3'(i));
        // Edges come from synchronised stages one and two only.
        wire rise = pinSync[1] && !pinSync[2];
        wire fall = !pinSync[1] && pinSync[2];
        wire capEvent = !cmpMode && running
            && ((edgeSel[0] && rise) || (edgeSel[1] && fall));
        wire cmpEvent = cmpMode && tick && nextCnt == chValue[i];
        wire chEvent = capEvent || cmpEvent;

        // Pin input synchroniser; the pin is asynchronous to sys_clk.
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                pinSync <= 3'h0;
            end else begin
                pinSync <= {pinSync[1:0], chPinIn[i]};
            end
        end

        // Control, flag with two-step clear, and compare output level.
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                flag <= 1'b0;
                ie <= 1'b0;
                cmpMode <= 1'b0;
                edgeSel <= 2'h0;
                armed <= 1'b0;
                pinLevel <= 1'b0;
            end else begin
                if (wrCh) begin
                    ie <= bus.wdata[CH_IE_BIT];
                    cmpMode <= bus.wdata[CH_CMP_BIT];
                    edgeSel <= bus.wdata[CH_EDGE_LSB +: 2];
                end
                if (chEvent) begin
                    flag <= 1'b1;
                end else if (wrCh && !bus.wdata[CH_FLAG_BIT] && armed
                    && !flagsLocked) begin
                    flag <= 1'b0;
                end
                if (chEvent) begin
                    armed <= 1'b0;
                end else if (rdCh && flag && !flagsLocked) begin
                    armed <= 1'b1;
                end else if (wrCh && !flagsLocked) begin
                    armed <= 1'b0;
                end
                if (cmpEvent) begin
                    case (edgeSel)
                        2'h1: pinLevel <= !pinLevel;
                        2'h2: pinLevel <= 1'b0;
                        2'h3: pinLevel <= 1'b1;
                        default: pinLevel <= pinLevel;
                    endcase
                end
            end
        end

        // Selection of pin ownership; edge select zero leaves the port.
        assign chPinOut[i] = pinLevel;
        assign chPinOe_n[i] = !(cmpMode && edgeSel != 2'h0);
        assign chIrq[i] = flag && ie;
        assign chReg[i] = {flag, ie, 1'b0, cmpMode, edgeSel, 2'h0};
    end

    // ------------------------------------------------------------
    // Read data and answer.
    // ------------------------------------------------------------
    // The reset bit always reads zero; unused indices read zero.
    wire [7:0] scRead = {overflow_flag, overflow_irq_enable, halt, 1'b0, 1'b0, ps};
    wire [7:0] cntLoRead = latched ? latchLow : cnt[7:0];
    wire [7:0] readMux = (bus.addr == IDX_SC) ? scRead
        : (bus.addr == IDX_CNT_HI) ? cnt[15:8]
        : (bus.addr == IDX_CNT_LO) ? cntLoRead
        : (bus.addr == IDX_MOD_HI) ? modulo[15:8]
        : (bus.addr == IDX_MOD_LO) ? modulo[7:0]
        : (bus.addr == IDX_CH0) ? chReg[0]
        : (bus.addr == IDX_CH1) ? chReg[1]
        : 8'h00;

    // One-cycle answer to every request, read or write.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ready <= 1'b0;
            rdata <= 8'h00;
        end else begin
            ready <= take;
            if (rd) begin
                rdata <= readMux;
            end
        end
    end

    assign bus.ready = ready;
    assign bus.rdata = rdata;
endmodule // tct_timer
`default_nettype wire

// File: inc/tct_pkg.sv
/*
 Holds the shared constants of the two-channel timer: register indices,
 field positions and reset values, and the controller's own map.
 Assumes both ends and the bench import it whole.
*/
// How it works
// - Debug break halts counter and captures
// - Clear-enable set: break clears stick afterwards
// - Clear-enable clear: break accesses keep flags
// - Prescaler runs only from bus clock
// - Each pin independently capture or compare
// - Counter reaching modulo sets overflow flag
// - Overflow clear: read set, write zero
// - Overflow request needs enable and flag
// - Halt bit freezes counter, set by reset
// - Halt bit also blocks input captures
// - Counter reset bit clears counter, prescaler
// - Halt plus counter reset holds zero
// - Prescale select divides by 1 to 64
// - High-byte read latches low byte once
// - Break latch holds until low read
// - Counter wraps to zero after modulo
// - Modulo high write blocks overflow until low
// - Reset sets modulo registers to ones
// - Software resets counter before modulo update
// - Channel flag on edge or match
// - Channel flag clear: read set, write zero
// - Software unhalts to clear flag, rehalts
// - Channel enable gates channel request
package tct_pkg;
    // ------------------------------------------------------------
    // Device register indices on the register link.
    // ------------------------------------------------------------
    localparam logic [2:0] IDX_SC = 3'h0;
    localparam logic [2:0] IDX_CNT_HI = 3'h1;
    localparam logic [2:0] IDX_CNT_LO = 3'h2;
    localparam logic [2:0] IDX_MOD_HI = 3'h3;
    localparam logic [2:0] IDX_MOD_LO = 3'h4;
    localparam logic [2:0] IDX_CH0 = 3'h5;
    localparam logic [2:0] IDX_CH1 = 3'h6;
    // ------------------------------------------------------------
    // Field positions and reset values.
    // ------------------------------------------------------------
    localparam int SC_FLAG_BIT = 7;
    localparam int SC_IE_BIT = 6;
    localparam int SC_HALT_BIT = 5;
    localparam int SC_RST_BIT = 4;
    localparam int SC_PS_LSB = 0;
    localparam logic [2:0] PS_UNUSED = 3'h7;
    localparam int CH_FLAG_BIT = 7;
    localparam int CH_IE_BIT = 6;
    localparam int CH_CMP_BIT = 4;
    localparam int CH_EDGE_LSB = 2;
    localparam logic [15:0] MOD_RESET = 16'hffff;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    // ------------------------------------------------------------
    // Controller APB map.
    // ------------------------------------------------------------
    localparam logic [7:0] HOST_CMD = 8'h00;
    localparam logic [7:0] HOST_STAT = 8'h04;
    localparam int CMD_WRITE_BIT = 16;
    localparam int CMD_ADDR_LSB = 8;
    localparam int STAT_DATA_LSB = 8;
    typedef enum logic {TCT_IDLE = 1'b0, TCT_REQ = 1'b1} tct_state_t;
endpackage

// File: inc/tct_reg_if.sv
/*
 Register link between the controller and the timer.
 Assumes one clock shared by both ends; the bench ties the instances.
*/
`timescale 1ns/1ps
`default_nettype none
interface tct_reg_if (
    input wire logic sys_clk
);
    logic sel;
    logic write;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ready;
    modport dev (input sel, write, addr, wdata, output rdata, ready);
    modport host (output sel, write, addr, wdata, input rdata, ready);
endinterface
`default_nettype wire

// File: logic/tct_host.sv
/*
 Controller end: takes one register access at a time from software
 over APB and plays it on the timer's register link.
 Assumes software polls the busy bit; the clearing sequences of the
 timer are software's business.
*/
`timescale 1ns/1ps
`default_nettype none
module tct_host (
    input wire logic sys_clk,
    input wire logic rst,
    tct_reg_if.host bus,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import tct_pkg::*;

    tct_state_t state;
    logic [2:0] reqAddr;
    logic [7:0] reqData;
    logic reqWrite;
    logic [7:0] lastRead;

    // ------------------------------------------------------------
    // APB decode.
    // ------------------------------------------------------------
    // A command while busy is dropped; software must poll first.
    wire apbWr = psel && penable && pwrite;
    wire start = apbWr && paddr == HOST_CMD && state == TCT_IDLE;
    wire setup = psel && !penable && !pwrite;
    wire busy = state == TCT_REQ;
    wire [31:0] readMux = (paddr == HOST_STAT)
        ? {16'h0000, lastRead, 7'h00, busy}
        : 32'h0000_0000;

    // Sequencer: select is held until the timer answers.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= TCT_IDLE;
            reqAddr <= 3'h0;
            reqData <= 8'h00;
            reqWrite <= 1'b0;
            lastRead <= 8'h00;
        end else begin
            case (state)
                TCT_IDLE: begin
                    if (start) begin
                        reqAddr <= pwdata[CMD_ADDR_LSB +: 3];
                        reqData <= pwdata[7:0];
                        reqWrite <= pwdata[CMD_WRITE_BIT];
                        state <= TCT_REQ;
                    end
                end
                TCT_REQ: begin
                    if (bus.ready) begin
                        if (!reqWrite) begin
                            lastRead <= bus.rdata;
                        end
                        state <= TCT_IDLE;
                    end
                end
                default: state <= TCT_IDLE;
            endcase
        end
    end

    // Read data is fetched in the setup cycle, so no wait is needed.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= readMux;
        end
    end

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign bus.sel = busy;
    assign bus.write = reqWrite;
    assign bus.addr = reqAddr;
    assign bus.wdata = reqData;
endmodule // tct_host
`default_nettype wire

// File: verif/tct_chk.sv
/*
 Checker for the register link that joins the controller to the timer.
 Assumes the bench instantiates it once, beside the link instance.
*/
`timescale 1ns/1ps
`default_nettype none
module tct_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sel,
    input wire logic write,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic ready
);
    import tct_pkg::*;
    // --------------------
    // Helper state
    // --------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic scDone;
    logic modDone;
    wire rdDone = ready && !write;
    wire scRead = rdDone && (addr == IDX_SC);
    wire modSel = (addr == IDX_MOD_HI) || (addr == IDX_MOD_LO);
    // Reset values are judged only until software first overwrites them.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            scDone <= 1'b0;
            modDone <= 1'b0;
        end else if (ready && write) begin
            scDone <= scDone || (addr == IDX_SC);
            modDone <= modDone || modSel;
        end
    end
    // --------------------
    // Link handshake
    // --------------------
    // Every request is answered by one pulse, one cycle after the take.
    AST_READY_ANSWER: assert property (sel && !ready |=> ready)
        else $error("ready missing after a request");
    AST_READY_PULSE: assert property (ready |=> !ready)
        else $error("ready held longer than one cycle");
    AST_READY_CAUSE: assert property (ready |-> $past(sel))
        else $error("ready without a request");
    // The controller holds a request until answered, then drops it.
    AST_SEL_HOLD: assert property (sel && !ready |=>
        sel && $stable({addr, write, wdata}))
        else $error("request changed before answer");
    AST_SEL_DROP: assert property (sel && ready |=> !sel)
        else $error("request not dropped after answer");
    // --------------------
    // Register read-back
    // --------------------
    AST_RST_BIT_ZERO: assert property (
        scRead |-> !rdata[SC_RST_BIT])
        else $error("counter reset bit read as one");
    AST_HALT_AT_RESET: assert property (
        scRead && !scDone |-> rdata[SC_HALT_BIT] && !rdata[SC_IE_BIT])
        else $error("halt or enable wrong after reset");
    AST_MOD_AT_RESET: assert property (
        rdDone && modSel && !modDone |-> rdata == 8'hff)
        else $error("modulo not all ones after reset");
    AST_UNUSED_ZERO: assert property (
        rdDone && (addr == 3'h7) |-> rdata == 8'h00)
        else $error("unused index read not zero");
endmodule // tct_chk
`default_nettype wire

// File: verif/two_channel_timer_control_tb_top.sv
/*
 Self-checking bench: controller and timer joined by the link, APB
 driven here, the link checker beside them.
 Assumes package, interface and design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module two_channel_timer_control_tb_top;
    import tct_pkg::*;
    typedef struct packed {
        logic [2:0] idx;
        logic [7:0] wd;
        logic [7:0] exp;
    } tct_row_t;
    // --------------------
    // Signals and instances
    // --------------------
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic debugBreak = 1'b0;
    logic breakClearEnable = 1'b0;
    logic [1:0][15:0] chValue = 32'h0;
    logic [1:0] chPinIn = 2'h0;
    logic [1:0] chPinOut;
    logic [1:0] chPinOe_n;
    logic ovfIrq;
    logic [1:0] chIrq;
    logic [7:0] rv;
    logic [7:0] c1;
    int miscompares = 0;
    int tests_run = 0;
    int n;
    // Row: register, value written, value read back after it.
    tct_row_t rows [8] = '{
        '{IDX_SC, 8'ha3, 8'h23},
        '{IDX_SC, 8'h36, 8'h26},
        '{IDX_MOD_HI, 8'h12, 8'h12},
        '{IDX_MOD_LO, 8'h34, 8'h34},
        '{IDX_CH0, 8'hd4, 8'h54},
        '{IDX_CH1, 8'hc8, 8'h48},
        '{IDX_CNT_HI, 8'hff, 8'h00},
        '{3'h7, 8'h55, 8'h00}
    };
    // Free-running bus clock, 40 ns period.
    always #20 sys_clk = ~sys_clk;
    tct_reg_if u_tct_reg_if (.sys_clk(sys_clk));
    tct_timer u_tct_timer (.sys_clk(sys_clk), .rst(rst),
        .bus(u_tct_reg_if), .debugBreak(debugBreak),
        .breakClearEnable(breakClearEnable), .chValue(chValue),
        .chPinIn(chPinIn), .chPinOut(chPinOut), .chPinOe_n(chPinOe_n),
        .ovfIrq(ovfIrq), .chIrq(chIrq));
    tct_host u_tct_host (.sys_clk(sys_clk), .rst(rst),
        .bus(u_tct_reg_if), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    tct_chk u_tct_chk (.sys_clk(sys_clk), .rst(rst),
        .sel(u_tct_reg_if.sel), .write(u_tct_reg_if.write),
        .addr(u_tct_reg_if.addr), .wdata(u_tct_reg_if.wdata),
        .rdata(u_tct_reg_if.rdata), .ready(u_tct_reg_if.ready));
    // --------------------
    // Tasks
    // --------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h want %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; the request stays put until pready is sampled.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1 && k < 20) begin
            k++;
            @(posedge sys_clk);
        end
        if (pready !== 1'b1) begin
            miscompares++;
            $display("mismatch at %0t: no pready", $time);
        end
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Commands dropped while busy are lost, so wait for idle each time.
    task automatic link(input logic wr, input logic [2:0] i,
                        input logic [7:0] d, output logic [7:0] q);
        logic [31:0] r;
        int k;
        k = 0;
        apb(1'b1, HOST_CMD, {15'h0, wr, 5'h0, i, d}, r);
        r = 32'h1;
        while (r[0] !== 1'b0 && k < 10) begin
            apb(1'b0, HOST_STAT, 32'h0, r);
            k++;
        end
        check(r[0], 1'b0);
        q = r[STAT_DATA_LSB +: 8];
    endtask
    task automatic wr(input logic [2:0] i, input logic [7:0] d);
        link(1'b1, i, d, rv);
    endtask
    task automatic rd(input logic [2:0] i, input logic [7:0] e);
        link(1'b0, i, 8'h00, rv);
        check(rv, e);
    endtask
    task automatic do_reset();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
    endtask
    task automatic stop_test();
        $display("tests_run %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // --------------------
    // Main sequence
    // --------------------
    initial begin
        do_reset();
        foreach (rows[i]) begin
            wr(rows[i].idx, rows[i].wd);
            rd(rows[i].idx, rows[i].exp);
        end
        for (int p = 0; p < 7; p++) begin
            wr(IDX_SC, 8'h20 | 8'(p));
            rd(IDX_SC, 8'h20 | 8'(p));
        end
        $display("row tests done");
        do_reset();
        rd(IDX_SC, 8'h20);
        rd(IDX_MOD_HI, 8'hff);
        rd(IDX_MOD_LO, 8'hff);
        rd(IDX_CNT_HI, 8'h00);
        rd(IDX_CNT_LO, 8'h00);
        rd(IDX_CH0, 8'h00);
        check({ovfIrq, chIrq, chPinOe_n}, 8'h03);
        $display("reset test done");
        // Divide by 64 for 640 cycles gives ten ticks, plus link slack.
        wr(IDX_SC, 8'h16);
        repeat (640) @(posedge sys_clk);
        wr(IDX_SC, 8'h26);
        rd(IDX_CNT_HI, 8'h00);
        link(1'b0, IDX_CNT_LO, 8'h00, c1);
        check(c1 == 8'h0a || c1 == 8'h0b, 1'b1);
        repeat (50) @(posedge sys_clk);
        rd(IDX_CNT_HI, 8'h00);
        rd(IDX_CNT_LO, c1);
        wr(IDX_SC, 8'h30);
        rd(IDX_CNT_HI, 8'h00);
        rd(IDX_CNT_LO, 8'h00);
        $display("count test done");
        wr(IDX_MOD_HI, 8'h00);
        wr(IDX_MOD_LO, 8'h05);
        wr(IDX_SC, 8'h40);
        n = 0;
        while (ovfIrq !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        check(ovfIrq, 1'b1);
        wr(IDX_SC, 8'h60);
        rd(IDX_CNT_HI, 8'h00);
        link(1'b0, IDX_CNT_LO, 8'h00, c1);
        check(c1 <= 8'h05, 1'b1);
        rd(IDX_SC, 8'he0);
        wr(IDX_SC, 8'h60);
        rd(IDX_SC, 8'h60);
        check(ovfIrq, 1'b0);
        // A pending modulo high write must hold off every overflow.
        wr(IDX_SC, 8'h70);
        wr(IDX_MOD_HI, 8'h00);
        wr(IDX_SC, 8'h40);
        repeat (20) @(posedge sys_clk);
        check(ovfIrq, 1'b0);
        wr(IDX_MOD_LO, 8'h05);
        $display("overflow test done");
        wr(IDX_SC, 8'h00);
        repeat (20) @(posedge sys_clk);
        debugBreak <= 1'b1;
        rd(IDX_CNT_HI, 8'h00);
        link(1'b0, IDX_CNT_LO, 8'h00, c1);
        repeat (20) @(posedge sys_clk);
        rd(IDX_CNT_HI, 8'h00);
        rd(IDX_CNT_LO, c1);
        rd(IDX_CNT_HI, 8'h00);
        rd(IDX_SC, 8'h80);
        check(ovfIrq, 1'b0);
        wr(IDX_SC, 8'h00);
        rd(IDX_SC, 8'h80);
        breakClearEnable <= 1'b1;
        rd(IDX_SC, 8'h80);
        wr(IDX_SC, 8'h20);
        rd(IDX_SC, 8'h20);
        debugBreak <= 1'b0;
        breakClearEnable <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rd(IDX_SC, 8'h20);
        // The byte latched in the break survives a running counter.
        wr(IDX_SC, 8'h00);
        repeat (3) @(posedge sys_clk);
        rd(IDX_CNT_HI, 8'h00);
        rd(IDX_CNT_LO, c1);
        wr(IDX_SC, 8'h20);
        $display("break test done");
        // Channel 0 sets its pin on match, channel 1 captures rises.
        chValue[0] <= 16'h0003;
        wr(IDX_CH0, 8'h5c);
        wr(IDX_CH1, 8'h44);
        chPinIn[1] <= 1'b1;
        repeat (10) @(posedge sys_clk);
        check(chIrq[1], 1'b0);
        chPinIn[1] <= 1'b0;
        wr(IDX_SC, 8'h00);
        chPinIn[1] <= 1'b1;
        n = 0;
        while (chIrq !== 2'h3 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        check(chIrq, 2'h3);
        check({chPinOut[0], chPinOe_n}, 3'h6);
        // Clear with the counter running slowly, then halt again; the
        // next match is many link accesses away.
        wr(IDX_SC, 8'h30);
        wr(IDX_SC, 8'h06);
        rd(IDX_CH0, 8'hdc);
        wr(IDX_CH0, 8'h5c);
        wr(IDX_SC, 8'h20);
        rd(IDX_CH0, 8'h5c);
        check(chIrq[0], 1'b0);
        $display("channel test done");
        stop_test();
    end
    // Cuts a hang short; the whole run needs under two thousand cycles.
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        $display("mismatch at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule // two_channel_timer_control_tb_top
`default_nettype wire
